// *** design/adc_seq_regs.vh ***
`ifndef ADC_SEQ_REGS_VH
`define ADC_SEQ_REGS_VH

// Register indices (byte address = index * 4)
`define IDX_MODE        8'h00
`define IDX_DATA_FIRST  8'h02
`define IDX_DATA_LAST   8'h09
`define IDX_INTCFG      8'h12
`define IDX_SLPCFG      8'h13
`define IDX_ACQCFG      8'h14
`define IDX_PWRCFG      8'h15
`define IDX_STATUS      8'h17

// Reset values
`define RST_MODE        8'h00
`define RST_INTCFG      8'hE0
`define RST_SLPCFG      8'h00
`define RST_ACQCFG      8'h00
`define RST_PWRCFG      8'h00

// Field positions
`define MODE_HI         7
`define MODE_LO         2
`define INTCFG_PER_CONV 3
`define INTCFG_BUSY     2
`define INTCFG_POL      1
`define SLPCFG_STOP     6
`define PWRCFG_AMP_EN   5
`define PWRCFG_AMP_POL  6

// Mode codes
`define MODE_IDLE       6'h00
`define MODE_AWAKE      6'h20
`define MODE_MSINGLE    6'h30
`define MODE_MSCAN      6'h32
`define MODE_ASINGLE    6'h33
`define MODE_ASCAN      6'h3B
`define MODE_ASLEEP     6'h39

// Timing
`define CLK_MHZ         25
`define PU_STEP_US      2
`define ACQ_STEP_US     2
`define ACQ_MIN_US      6
`define CONV_US         4
`define SLEEP_UNIT_US   10
`define PU_STEP_CYC     (`PU_STEP_US * `CLK_MHZ)
`define ACQ_STEP_CYC    (`ACQ_STEP_US * `CLK_MHZ)
`define ACQ_MIN_CYC     (`ACQ_MIN_US * `CLK_MHZ)
`define CONV_CYC        (`CONV_US * `CLK_MHZ)
`define SLEEP_UNIT_CYC  (`SLEEP_UNIT_US * `CLK_MHZ)

`endif

// *** design/adc_mode_sequencer.v ***
// Notes on behaviour
// - Awake keeps everything powered, converter ready
// - Idle powers everything down, no conversions
// - Manual single: power-up, acquire, convert once
// - Zero power-up field skips the wait
// - Acquisition length from five-bit config field
// - After manual single, wait for new mode
// - Power-up only on first converting mode after reset or idle
// - Manual single may repeat without awake
// - Manual scan: four channels, acquire each
// - Scan advances channel, wraps three to zero
// - Result stored by converted channel number
// - Scan results per conversion; ready each/all
// - Manual scan may repeat without awake
// - Auto single converts same channel continuously
// - Alarm either stops or continues auto modes
// - Auto scan converts all channels continuously
// - Auto single sleep: sleep after each conversion
// - Amplifier control disabled during every sleep
// - Mode starts at trailing acknowledge edge
// - Busy or data ready routed to interrupt
// - Acquisition is field times 2us plus 6us
// - Power-up is field times 2us
// - Conversion takes fixed 4us
// - Mode codes decode as documented
`include "adc_seq_regs.vh"
`default_nettype none

module adc_mode_sequencer (
    input  wire        clk,
    input  wire        resetn,
    input  wire        ce,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [9:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        scl_in,
    input  wire [11:0] adc_data_in,
    input  wire        alarm_in,
    output reg         converter_power_on,
    output reg         amp_power_control_out,
    output reg         conv_start,
    output reg  [1:0]  mux_sel,
    output reg         int_out
);

    localparam [6:0] ST_IDLE  = 7'h01;
    localparam [6:0] ST_AWAKE = 7'h02;
    localparam [6:0] ST_PWRUP = 7'h04;
    localparam [6:0] ST_ACQ   = 7'h08;
    localparam [6:0] ST_CONV  = 7'h10;
    localparam [6:0] ST_SLEEP = 7'h20;
    localparam [6:0] ST_DONE  = 7'h40;

    // Counter preload for an interval of n cycles; the counter ends at zero
    function [15:0] cycles_to_load;
        input [31:0] n;
        reg   [31:0] t;
        begin
            t              = n - 32'h0000_0001;
            cycles_to_load = t[15:0];
        end
    endfunction

    function [15:0] cnt_dec;
        input [15:0] c;
        begin
            cnt_dec = c - 16'h0001;
        end
    endfunction

    function [15:0] acq_load;
        input [4:0] f;
        reg   [31:0] t;
        begin
            t        = {27'h0000000, f} * `ACQ_STEP_CYC + `ACQ_MIN_CYC;
            acq_load = cycles_to_load(t);
        end
    endfunction

    // A zero field wraps here; the sequencer never loads it
    function [15:0] pu_load;
        input [4:0] f;
        reg   [31:0] t;
        begin
            t       = {27'h0000000, f} * `PU_STEP_CYC;
            pu_load = cycles_to_load(t);
        end
    endfunction

    function [15:0] sleep_load;
        input [2:0] f;
        reg   [31:0] t;
        begin
            t          = ({29'h00000000, f} + 32'h0000_0001) * `SLEEP_UNIT_CYC;
            sleep_load = cycles_to_load(t);
        end
    endfunction

    function is_scan_mode;
        input [5:0] m;
        begin
            is_scan_mode = (m == `MODE_MSCAN) || (m == `MODE_ASCAN);
        end
    endfunction

    // Modes that keep converting until the next mode write or an alarm stop
    function is_auto_mode;
        input [5:0] m;
        begin
            is_auto_mode = (m == `MODE_ASINGLE) || (m == `MODE_ASCAN) ||
                           (m == `MODE_ASLEEP);
        end
    endfunction

    reg [5:0]  mode_q;
    reg [1:0]  sel_q;
    reg [7:0]  intcfg_q;
    reg [7:0]  slpcfg_q;
    reg [7:0]  acqcfg_q;
    reg [7:0]  pwrcfg_q;
    reg [11:0] res_q [0:3];
    reg        pend_q;
    reg        scl_s1_q;
    reg        scl_s2_q;
    reg        scl_s3_q;
    reg [6:0]  state_q;
    reg [15:0] cnt_q;
    reg [2:0]  left_q;
    reg        scan_q;
    reg        auto_q;
    reg        sleepy_q;
    reg        pu_done_q;
    reg [1:0]  last_ch_q;
    reg        dready_q;
    reg        busy_q;

    wire [7:0] idx       = paddr[9:2];
    wire       access    = psel & penable & pready;
    wire       wr        = access & pwrite;
    wire       rd        = access & ~pwrite;
    wire       is_data   = (idx >= `IDX_DATA_FIRST) && (idx <= `IDX_DATA_LAST);
    wire [7:0] data_off  = idx - `IDX_DATA_FIRST;
    wire [1:0] data_ch   = data_off[2:1];
    // Falling link clock edge ends the acknowledge of a mode write
    wire       ack_edge  = scl_s3_q & ~scl_s2_q;
    wire       start     = pend_q & ack_edge;
    wire       mode_wr   = wr && (idx == `IDX_MODE);
    wire       cnt_zero  = (cnt_q == 16'h0000);
    wire       conv_end  = (state_q == ST_CONV) && cnt_zero;
    wire       alarm_stop = auto_q & slpcfg_q[`SLPCFG_STOP] & alarm_in;
    wire       last_conv = (left_q == 3'h1) & ~auto_q;
    wire       skip_pu   = pu_done_q | (pwrcfg_q[4:0] == 5'h00);

    reg        mapped;
    reg [31:0] rdata;
    always @* begin
        mapped = 1'b1;
        rdata  = 32'h0000_0000;
        if (is_data) begin
            if (data_off[0])
                rdata[7:0] = {res_q[data_ch][3:0], 4'h0};
            else
                rdata[7:0] = res_q[data_ch][11:4];
        end else begin
            case (idx)
                `IDX_MODE:   rdata[7:0] = {mode_q, last_ch_q};
                `IDX_INTCFG: rdata[7:0] = intcfg_q;
                `IDX_SLPCFG: rdata[7:0] = slpcfg_q;
                `IDX_ACQCFG: rdata[7:0] = acqcfg_q;
                `IDX_PWRCFG: rdata[7:0] = pwrcfg_q;
                `IDX_STATUS: rdata[8:0] = {state_q, dready_q, busy_q};
                default:     mapped = 1'b0;
            endcase
        end
    end

    // Bus slave, one wait state per transfer
    always @(posedge clk) begin
        if (!resetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (ce) begin
            if (psel && penable && !pready) begin
                pready  <= 1'b1;
                pslverr <= ~mapped;
                prdata  <= pwrite ? 32'h0000_0000 : rdata;
            end else begin
                pready  <= 1'b0;
                pslverr <= 1'b0;
            end
        end
    end

    // Config registers
    always @(posedge clk) begin
        if (!resetn) begin
            mode_q   <= `MODE_IDLE;
            sel_q    <= 2'h0;
            intcfg_q <= `RST_INTCFG;
            slpcfg_q <= `RST_SLPCFG;
            acqcfg_q <= `RST_ACQCFG;
            pwrcfg_q <= `RST_PWRCFG;
        end else if (ce && wr) begin
            case (idx)
                `IDX_MODE: begin
                    mode_q <= pwdata[`MODE_HI:`MODE_LO];
                    sel_q  <= pwdata[1:0];
                end
                `IDX_INTCFG: intcfg_q <= pwdata[7:0];
                // Unused bits stay zero on read back
                `IDX_SLPCFG: slpcfg_q <= pwdata[7:0] & 8'h77;
                `IDX_ACQCFG: acqcfg_q <= pwdata[7:0] & 8'h1F;
                `IDX_PWRCFG: pwrcfg_q <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // Link clock synchroniser and pending mode start
    // Stages reset to the idle-high line, so reset gives no false edge
    always @(posedge clk) begin
        if (!resetn) begin
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            scl_s3_q <= 1'b1;
            pend_q   <= 1'b0;
        end else if (ce) begin
            scl_s1_q <= scl_in;
            scl_s2_q <= scl_s1_q;
            scl_s3_q <= scl_s2_q;
            if (mode_wr)
                pend_q <= 1'b1;
            else if (ack_edge)
                pend_q <= 1'b0;
        end
    end

    // Sequencer
    always @(posedge clk) begin
        if (!resetn) begin
            state_q    <= ST_IDLE;
            cnt_q      <= 16'h0000;
            left_q     <= 3'h0;
            scan_q     <= 1'b0;
            auto_q     <= 1'b0;
            sleepy_q   <= 1'b0;
            pu_done_q  <= 1'b0;
            mux_sel    <= 2'h0;
            last_ch_q  <= 2'h0;
            conv_start <= 1'b0;
            res_q[0]   <= 12'h000;
            res_q[1]   <= 12'h000;
            res_q[2]   <= 12'h000;
            res_q[3]   <= 12'h000;
        end else if (ce) begin
            conv_start <= 1'b0;
            if (start) begin
                mux_sel  <= sel_q;
                scan_q   <= is_scan_mode(mode_q);
                auto_q   <= is_auto_mode(mode_q);
                sleepy_q <= (mode_q == `MODE_ASLEEP);
                left_q   <= (mode_q == `MODE_MSCAN) ? 3'h4 : 3'h1;
                case (mode_q)
                    `MODE_IDLE: begin
                        // Idle forgets the power-up, so the next run waits again
                        state_q   <= ST_IDLE;
                        pu_done_q <= 1'b0;
                    end
                    `MODE_MSINGLE, `MODE_MSCAN, `MODE_ASINGLE, `MODE_ASCAN,
                    `MODE_ASLEEP: begin
                        // Repeated manual commands restart here directly
                        if (skip_pu) begin
                            state_q <= ST_ACQ;
                            cnt_q   <= acq_load(acqcfg_q[4:0]);
                        end else begin
                            state_q <= ST_PWRUP;
                            cnt_q   <= pu_load(pwrcfg_q[4:0]);
                        end
                    end
                    default: state_q <= ST_AWAKE;
                endcase
            end else begin
                case (state_q)
                    ST_PWRUP: begin
                        if (cnt_zero) begin
                            pu_done_q <= 1'b1;
                            state_q   <= ST_ACQ;
                            cnt_q     <= acq_load(acqcfg_q[4:0]);
                        end else
                            cnt_q <= cnt_dec(cnt_q);
                    end
                    ST_ACQ: begin
                        if (cnt_zero) begin
                            state_q    <= ST_CONV;
                            conv_start <= 1'b1;
                            cnt_q      <= cycles_to_load(`CONV_CYC);
                        end else
                            cnt_q <= cnt_dec(cnt_q);
                    end
                    ST_CONV: begin
                        if (cnt_zero) begin
                            // Converter result is valid on the last conversion cycle
                            res_q[mux_sel] <= adc_data_in;
                            last_ch_q      <= mux_sel;
                            left_q         <= left_q - 3'h1;
                            if (scan_q)
                                mux_sel <= mux_sel + 2'h1;
                            if (alarm_stop || last_conv) begin
                                state_q <= ST_DONE;
                            end else if (sleepy_q) begin
                                state_q <= ST_SLEEP;
                                cnt_q   <= sleep_load(slpcfg_q[2:0]);
                            end else begin
                                state_q <= ST_ACQ;
                                cnt_q   <= acq_load(acqcfg_q[4:0]);
                            end
                        end else
                            cnt_q <= cnt_dec(cnt_q);
                    end
                    ST_SLEEP: begin
                        if (cnt_zero) begin
                            state_q <= ST_ACQ;
                            cnt_q   <= acq_load(acqcfg_q[4:0]);
                        end else
                            cnt_q <= cnt_dec(cnt_q);
                    end
                    ST_IDLE, ST_AWAKE, ST_DONE: cnt_q <= 16'h0000;
                    default: state_q <= ST_IDLE;
                endcase
            end
        end
    end

    // Busy, data ready, interrupt routing, power outputs
    always @(posedge clk) begin
        if (!resetn) begin
            busy_q                <= 1'b0;
            dready_q              <= 1'b0;
            int_out               <= 1'b0;
            converter_power_on    <= 1'b0;
            amp_power_control_out <= 1'b0;
        end else if (ce) begin
            busy_q <= (state_q == ST_PWRUP) || (state_q == ST_ACQ) ||
                      (state_q == ST_CONV);
            // Per-conversion or end-of-scan ready; set wins over read clear
            if (conv_end && (!scan_q || auto_q || intcfg_q[`INTCFG_PER_CONV] ||
                             left_q == 3'h1))
                dready_q <= 1'b1;
            else if (rd && is_data && data_off[0])
                dready_q <= 1'b0;
            int_out <= (intcfg_q[`INTCFG_BUSY] ? busy_q : dready_q) ^
                       ~intcfg_q[`INTCFG_POL];
            converter_power_on <= (state_q != ST_IDLE) && (state_q != ST_SLEEP);
            if ((state_q == ST_IDLE) || (state_q == ST_SLEEP) ||
                !pwrcfg_q[`PWRCFG_AMP_EN])
                amp_power_control_out <= ~pwrcfg_q[`PWRCFG_AMP_POL];
            else
                amp_power_control_out <= pwrcfg_q[`PWRCFG_AMP_POL];
        end
    end

endmodule // adc_mode_sequencer

`default_nettype wire

// *** tb/adc_seq_sva.sv ***
`default_nettype none
module adc_seq_sva (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        ce,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [9:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        scl_in,
    input wire logic [11:0] adc_data_in,
    input wire logic        alarm_in,
    input wire logic        converter_power_on,
    input wire logic        amp_power_control_out,
    input wire logic        conv_start,
    input wire logic [1:0]  mux_sel,
    input wire logic        int_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] gap_q;
    // Cycles since the last conversion start, saturating
    always @(posedge clk) begin
        if (!resetn)
            gap_q <= 10'h3FF;
        else if (conv_start)
            gap_q <= 10'h000;
        else if (gap_q != 10'h3FF)
            gap_q <= gap_q + 10'h001;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
    property p_one_wait; psel && penable && !$past(penable) |=> pready; endproperty
    a_one_wait: assert property (p_one_wait) else $error("pready late");
    property p_err_zero; pslverr |-> pready && prdata == 32'h0000_0000; endproperty
    a_err_zero: assert property (p_err_zero) else $error("bad error response");
    property p_top_zero; pready |-> prdata[31:9] == 23'h000000; endproperty
    a_top_zero: assert property (p_top_zero) else $error("read data upper bits set");
    property p_conv_power; conv_start |-> converter_power_on; endproperty
    a_conv_power: assert property (p_conv_power) else $error("conversion while off");
    property p_mux_hold; conv_start |=> $stable(mux_sel)[*8]; endproperty
    a_mux_hold: assert property (p_mux_hold) else $error("channel moved in conversion");
    property p_conv_gap; conv_start |-> gap_q >= 10'h0F8; endproperty
    a_conv_gap: assert property (p_conv_gap) else $error("conversions too close");
    // Bench keeps the amplifier polarity at its reset value, so disabled is high
    property p_amp_sleep;
        !converter_power_on && !$past(converter_power_on) && $past(resetn, 2)
            |-> amp_power_control_out;
    endproperty
    a_amp_sleep: assert property (p_amp_sleep) else $error("amplifier on while off");
endmodule // adc_seq_sva
bind adc_mode_sequencer adc_seq_sva i_sva (
    .clk(clk), .resetn(resetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_in(scl_in), .adc_data_in(adc_data_in), .alarm_in(alarm_in),
    .converter_power_on(converter_power_on),
    .amp_power_control_out(amp_power_control_out),
    .conv_start(conv_start), .mux_sel(mux_sel), .int_out(int_out));
`default_nettype wire

// *** tb/host_link_model.sv ***
`default_nettype none
module host_link_model (
    output logic        scl,
    input  wire logic [1:0]  mux_sel,
    output logic [11:0] adc_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // Converter result carries the channel in its top bits
    assign adc_data = {mux_sel, 10'h2A5};
    initial scl = 1'b1;
    // Byte clocks up to the acknowledge high phase; the line rests high between frames
    task automatic frame();
        #5;
        repeat (9) begin
            scl = 1'b0;
            #160;
            scl = 1'b1;
            #160;
        end
    endtask
    // Trailing edge of the acknowledge, once the register write has landed
    task automatic ack_end();
        #5;
        scl = 1'b0;
        #160;
        scl = 1'b1;
    endtask
endmodule // host_link_model
`default_nettype wire

// *** tb/tb_adc_mode_sequencer.sv ***
`include "adc_seq_regs.vh"
`default_nettype none
module tb_adc_mode_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [9:0]  paddr = 10'h000;
    logic [31:0] pwdata = 32'h0;
    logic        alarm_in = 1'b0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, scl, conv_start, cpo, amp, int_out, err, off;
    logic [1:0]  mux_sel;
    logic [11:0] adc_data;
    int          miscompares = 0;
    int          n_checks = 0;
    int          cycles = 0;
    int          c0, c1, c2;
    always #20 clk = ~clk;
    adc_mode_sequencer i_dut (.clk(clk), .resetn(resetn), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .scl_in(scl), .adc_data_in(adc_data),
        .alarm_in(alarm_in), .converter_power_on(cpo), .amp_power_control_out(amp),
        .conv_start(conv_start), .mux_sel(mux_sel), .int_out(int_out));
    host_link_model i_host (.scl(scl), .mux_sel(mux_sel), .adc_data(adc_data));
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        if (n == 20)
            miscompares++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        chk(rd, {24'h0, exp});
    endtask
    task automatic mode(input logic [5:0] m, input logic [1:0] s);
        i_host.frame();
        @(posedge clk);
        apb(1'b1, `IDX_MODE, {m, s});
        i_host.ack_end();
        @(posedge clk);
    endtask
    // Cycles until a conversion starts; off notes any powered-down cycle
    task automatic wait_conv(input int lim, output int n);
        n = 0;
        off = 1'b0;
        do begin
            @(posedge clk);
            n++;
            if (cpo === 1'b0)
                off = 1'b1;
        end while (conv_start !== 1'b1 && n < lim);
    endtask
    task automatic s_regs();
        rd_chk(`IDX_INTCFG, `RST_INTCFG);
        rd_chk(`IDX_ACQCFG, `RST_ACQCFG);
        apb(1'b1, 8'h20, 8'h5A);
        chk({31'h0, err}, 1);
        chk(rd, 0);
        chk({31'h0, cpo}, 0);
    endtask
    task automatic s_manual_single();
        apb(1'b1, `IDX_PWRCFG, 8'h20);
        mode(`MODE_AWAKE, 2'h0);
        chk({31'h0, cpo}, 1);
        mode(`MODE_MSINGLE, 2'h2);
        wait_conv(2000, c0);
        chk({30'h0, mux_sel}, 2);
        chk({31'h0, int_out}, 1);
        repeat (110) @(posedge clk);
        chk({31'h0, int_out}, 0);
        rd_chk(8'h06, 8'hAA);
        rd_chk(8'h07, 8'h50);
        wait_conv(400, c1);
        chk(c1, 400);
        mode(`MODE_IDLE, 2'h0);
        apb(1'b1, `IDX_PWRCFG, 8'h21);
        mode(`MODE_AWAKE, 2'h0);
        mode(`MODE_MSINGLE, 2'h2);
        wait_conv(2000, c1);
        chk(c1 - c0, 50);
        repeat (110) @(posedge clk);
        mode(`MODE_MSINGLE, 2'h2);
        wait_conv(2000, c2);
        chk(c2, c0);
        repeat (110) @(posedge clk);
        apb(1'b1, `IDX_ACQCFG, 8'h01);
        mode(`MODE_MSINGLE, 2'h2);
        wait_conv(2000, c1);
        chk(c1 - c2, 50);
        repeat (110) @(posedge clk);
        apb(1'b1, `IDX_ACQCFG, 8'h00);
        apb(1'b1, `IDX_PWRCFG, 8'h20);
    endtask
    task automatic s_manual_scan();
        mode(`MODE_AWAKE, 2'h0);
        for (int s = 2; s >= 0; s -= 2) begin
            rd_chk(8'h07, 8'h50);
            mode(`MODE_MSCAN, 2'(s));
            for (int i = 0; i < 4; i++) begin
                wait_conv(2000, c0);
                chk({30'h0, mux_sel}, (s + i) % 4);
                chk({31'h0, int_out}, 1);
            end
            wait_conv(400, c0);
            chk(c0, 400);
            chk({31'h0, int_out}, 0);
        end
        for (int ch = 0; ch < 4; ch++) begin
            rd_chk(8'(2 + 2 * ch), {2'(ch), 6'h2A});
            rd_chk(8'(3 + 2 * ch), 8'h50);
        end
        rd_chk(`IDX_MODE, {`MODE_MSCAN, 2'h3});
    endtask
    task automatic s_auto();
        mode(`MODE_AWAKE, 2'h0);
        mode(`MODE_ASINGLE, 2'h1);
        repeat (3) begin
            wait_conv(2000, c1);
            chk({30'h0, mux_sel}, 1);
        end
        chk({31'h0, off}, 0);
        mode(`MODE_IDLE, 2'h0);
        wait_conv(400, c0);
        chk(c0, 400);
        chk({31'h0, cpo}, 0);
        mode(`MODE_AWAKE, 2'h0);
        mode(`MODE_ASCAN, 2'h3);
        for (int i = 0; i < 6; i++) begin
            wait_conv(2000, c0);
            chk({30'h0, mux_sel}, (3 + i) % 4);
        end
        mode(`MODE_IDLE, 2'h0);
        mode(`MODE_AWAKE, 2'h0);
        mode(`MODE_ASLEEP, 2'h0);
        wait_conv(2000, c0);
        wait_conv(2000, c2);
        chk(c2 - c1, 250);
        chk({31'h0, off}, 1);
        mode(`MODE_IDLE, 2'h0);
        apb(1'b1, `IDX_SLPCFG, 8'h40);
        alarm_in <= 1'b1;
        mode(`MODE_AWAKE, 2'h0);
        mode(`MODE_ASINGLE, 2'h0);
        wait_conv(2000, c0);
        wait_conv(600, c0);
        chk(c0, 600);
        alarm_in <= 1'b0;
        mode(`MODE_IDLE, 2'h0);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        s_regs();
        s_manual_single();
        s_manual_scan();
        s_auto();
        final_report();
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            miscompares++;
            final_report();
        end
    end
endmodule // tb_adc_mode_sequencer
`default_nettype wire
